// ---- touch_seq.sv ----
// Purpose: Reset, init, calibration and two-tier detection sequencer.
// Assumes: Analog front end delivers one burst result per burst_req_o.
// Notes: Registers over AHB-Lite, zero wait states.
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module touch_seq
    import touch_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_CYC,
    parameter int INIT_MOD_CYCLES = INIT_MOD_CYC
) (
    input wire logic sys_clk_i,               // 10 MHz clock.
    input wire logic resetn_i,                // Power-on reset, low.
    input wire logic ext_rst_n_i,             // External reset pin.
    input wire logic hsel,                    // AHB select.
    input wire logic [31:0] haddr,            // AHB address.
    input wire logic [1:0] htrans,            // AHB transfer type.
    input wire logic hwrite,                  // AHB write.
    input wire logic [2:0] hsize,             // AHB size.
    input wire logic [31:0] hwdata,           // AHB write data.
    input wire logic hready,                  // AHB bus ready.
    output logic [31:0] hrdata,               // AHB read data.
    output logic hreadyout,                   // AHB slave ready.
    output logic hresp,                       // AHB response.
    input wire logic sample_vld_i,            // Burst result valid.
    input wire sample_t sample_i,             // Burst result.
    input wire logic [NKEYS-1:0] key_fault_i, // Per-key faults.
    input wire logic [ST_BITS-1:0] line_i,    // Line faults.
    output logic burst_req_o,                 // Start burst pulse.
    output logic [4:0] burst_key_o,           // Key to burst.
    output logic comms_ready_o                // Init finished.
);
    typedef enum logic [4:0] {
        S_INIT  = 5'b00001,
        S_IDLE  = 5'b00010,
        S_BURST = 5'b00100,
        S_WAIT  = 5'b01000,
        S_TEST  = 5'b10000
    } state_t;

    typedef struct packed {
        state_t st;
        logic [17:0] init_cnt;
        logic [15:0] space_cnt;
        logic [23:0] test_cnt;
        logic test_due;
        logic [4:0] key;
        logic [3:0] bcnt;
        logic cal;
        logic [3:0] cal_n;
        logic [NKEYS-1:0] enable;
        logic [NKEYS-1:0] active;
        logic [NKEYS-1:0] calbusy;
        logic [NKEYS-1:0] keyerr;
        logic [NKEYS-1:0] low_sig;
        logic [NKEYS-1:0] cal_ok;
        logic [15:0] spacing;
        logic [23:0] test_per;
        logic [7:0] lower_signal_limit;
        logic setup_mod;
        logic soft_rst;
        logic req;
        logic rdy;
        logic [31:0] rdata;
        logic dph;
        logic dwr;
        logic [7:0] daddr;
    } st_t;
    st_t r, nxt;

    logic [3:0] scnt_r [NKEYS];
    logic [3:0] scnt_nxt [NKEYS];
    key_setup_t setup_r [NKEYS];
    logic pin_hit;
    logic blk_rst_n;
    logic [ST_BITS-1:0] st_err;
    logic boot_mod_r;

    // The block reset merges power-on, qualified pin, and force command.
    rst_qual u_rq (
        .sys_clk_i (sys_clk_i),
        .resetn_i (resetn_i),
        .pin_n_i (ext_rst_n_i),
        .hit_o (pin_hit)
    );
    logic rst_req_r;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_req_r <= 1'b0;
        end else begin
            rst_req_r <= pin_hit | r.soft_rst;
        end
    end
    assign blk_rst_n = resetn_i & ~rst_req_r;

    // The setups-modified mark is taken one cycle before the block reset,
    // since that reset clears r; it then selects the longer init.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            boot_mod_r <= 1'b0;
        end else if (pin_hit | r.soft_rst) begin
            boot_mod_r <= r.setup_mod;
        end
    end

    self_test u_st (
        .sys_clk_i (sys_clk_i),
        .rst_n_i (blk_rst_n),
        .slot_i (r.st == S_TEST),
        .enable_i (r.enable),
        .key_fault_i (key_fault_i),
        .low_sig_i (r.low_sig),
        .line_i (line_i),
        .err_o (st_err)
    );

    // -----------------------------------------------------------------
    // Sequencer and bus slave
    // -----------------------------------------------------------------
    // Fast confirm repeats bursts on one key; scan confirm steps per scan.
    always_comb begin
        key_setup_t ks;
        logic [4:0] nk;
        logic wrap;
        logic [3:0] blim;
        ks = setup_r[r.key];
        blim = r.cal ? 4'(CAL_BURSTS) : ks.burst_lim;
        nxt = r;
        nk = 5'd0;
        wrap = 1'b1;
        for (int i = NKEYS - 1; i >= 0; i--) begin
            if (r.enable[i] && 5'(i) > r.key) begin
                nk = 5'(i);
                wrap = 1'b0;
            end
        end
        for (int i = 0; i < NKEYS; i++) begin
            scnt_nxt[i] = scnt_r[i];
        end
        nxt.req = 1'b0;
        nxt.soft_rst = 1'b0;
        nxt.test_cnt = r.test_cnt + 24'h000001;
        if (r.test_cnt >= r.test_per) begin
            nxt.test_cnt = 24'h000000;
            nxt.test_due = 1'b1;
        end
        case (r.st)
            S_INIT: begin
                nxt.init_cnt = r.init_cnt + 18'h00001;
                if (r.init_cnt >= 18'(boot_mod_r ? INIT_MOD_CYCLES
                                                 : INIT_CYCLES)) begin
                    nxt.rdy = 1'b1;
                    nxt.st = S_IDLE;
                    nxt.key = 5'd0;
                end
            end
            S_IDLE: begin
                nxt.space_cnt = r.space_cnt + 16'h0001;
                if (r.space_cnt >= r.spacing) begin
                    nxt.space_cnt = 16'h0000;
                    if (r.enable == '0) begin
                        nxt.st = S_TEST;
                    end else if (!r.enable[r.key]) begin
                        nxt.key = wrap ? 5'd0 : nk;
                        if (wrap) begin
                            nxt.st = S_TEST;
                        end
                    end else begin
                        nxt.st = S_BURST;
                    end
                end
            end
            S_BURST: begin
                nxt.req = 1'b1;
                nxt.st = S_WAIT;
            end
            S_WAIT: begin
                if (sample_vld_i) begin
                    nxt.low_sig[r.key] = sample_i.level < r.lower_signal_limit;
                    if (sample_i.above) begin
                        nxt.bcnt = r.bcnt + 4'h1;
                    end else begin
                        nxt.bcnt = 4'h0;
                    end
                    if (sample_i.above && r.bcnt + 4'h1 < blim) begin
                        nxt.st = S_BURST;
                    end else begin
                        nxt.bcnt = 4'h0;
                        if (r.cal) begin
                            nxt.cal_ok[r.key] = sample_i.above;
                        end else if (sample_i.above) begin
                            if (scnt_r[r.key] + 4'h1 >= ks.scan_lim) begin
                                nxt.active[r.key] = 1'b1;
                                scnt_nxt[r.key] = ks.scan_lim;
                            end else begin
                                scnt_nxt[r.key] = scnt_r[r.key] + 4'h1;
                            end
                        end else begin
                            scnt_nxt[r.key] = 4'h0;
                            nxt.active[r.key] = 1'b0;
                        end
                        nxt.key = wrap ? 5'd0 : nk;
                        nxt.st = wrap ? S_TEST : S_IDLE;
                    end
                end
            end
            S_TEST: begin
                nxt.st = S_IDLE;
                if (r.cal) begin
                    nxt.cal_n = r.cal_n + 4'h1;
                    nxt.calbusy = r.calbusy & r.enable & ~r.cal_ok;
                    if ((r.calbusy & ~r.cal_ok) == '0 ||
                        r.cal_n + 4'h1 >= 4'(CAL_RETRY)) begin
                        nxt.cal = 1'b0;
                        nxt.keyerr = r.calbusy & r.enable & ~r.cal_ok;
                        nxt.calbusy = '0;
                    end
                end
                nxt.test_due = 1'b0;
            end
            default: nxt.st = S_INIT;
        endcase
        // Data phase: registers answer with zero wait states.
        nxt.dph = 1'b0;
        if (r.dph && r.dwr) begin
            case (r.daddr)
                A_CTRL: begin
                    if (hwdata[0]) begin
                        nxt.cal = 1'b1;
                        nxt.cal_n = 4'h0;
                        nxt.calbusy = r.enable;
                        nxt.cal_ok = '0;
                    end
                end
                A_ENABLE: begin
                    nxt.enable = hwdata[NKEYS-1:0];
                    nxt.setup_mod = 1'b1;
                end
                A_SPACING: nxt.spacing = hwdata[15:0];
                A_LIMITS: begin
                    nxt.lower_signal_limit = hwdata[7:0];
                    nxt.setup_mod = 1'b1;
                end
                A_CMD: nxt.soft_rst = (hwdata[7:0] == CMD_FORCE_RESET);
                A_TESTPER: nxt.test_per = hwdata[23:0];
                default: nxt.setup_mod = r.setup_mod | (r.daddr >= 8'h40);
            endcase
        end
        if (hsel && hready && htrans[1]) begin
            nxt.dph = 1'b1;
            nxt.dwr = hwrite;
            nxt.daddr = haddr[7:0];
            case (haddr[7:0])
                A_STAT: nxt.rdata = {16'h0000, 6'h00, |st_err || |r.keyerr,
                                     r.cal, 4'h0, r.cal_n};
                A_ENABLE: nxt.rdata = {8'h00, r.enable};
                A_ACTIVE: nxt.rdata = {8'h00, r.active};
                A_CALBUSY: nxt.rdata = {8'h00, r.calbusy};
                A_KEYERR: nxt.rdata = {8'h00, r.keyerr};
                A_STERR: nxt.rdata = {22'h000000, st_err};
                A_SPACING: nxt.rdata = {16'h0000, r.spacing};
                A_LIMITS: nxt.rdata = {24'h000000, r.lower_signal_limit};
                A_TESTPER: nxt.rdata = {8'h00, r.test_per};
                default: nxt.rdata = 32'h00000000;
            endcase
        end
    end

    // Per-key setups: the scan limit, and the burst limit outside calibration, come from the per-key setup block.
    always_ff @(posedge sys_clk_i or negedge blk_rst_n) begin
        if (!blk_rst_n) begin
            for (int i = 0; i < NKEYS; i++) begin
                setup_r[i] <= '{burst_lim: BLIM_RST, scan_lim: SLIM_RST};
                scnt_r[i] <= 4'h0;
            end
        end else begin
            for (int i = 0; i < NKEYS; i++) begin
                scnt_r[i] <= scnt_nxt[i];
            end
            if (r.dph && r.dwr && r.daddr >= 8'h40 &&
                r.daddr < 8'h40 + 8'(NKEYS * 4)) begin
                setup_r[5'(r.daddr[6:2] - 5'd16)] <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge blk_rst_n) begin
        if (!blk_rst_n) begin
            r <= '0;
            r.st <= S_INIT;
            r.enable <= ENABLE_RST;
            r.spacing <= SPACING_RST;
            r.test_per <= TESTPER_RST;
            r.lower_signal_limit <= LSL_RST;
        end else begin
            r <= nxt;
        end
    end

    assign hrdata = r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign burst_req_o = r.req;
    assign burst_key_o = r.key;
    assign comms_ready_o = r.rdy;

    property p_init_time;
        @(posedge sys_clk_i) disable iff (!blk_rst_n)
        $rose(r.rdy) |-> r.init_cnt >= 18'(INIT_CYCLES);
    endproperty
    a_init_time: assert property (p_init_time)
        else $error("Comms ready before init time.");

    property p_disabled_skip;
        @(posedge sys_clk_i) disable iff (!blk_rst_n)
        burst_req_o |-> r.enable[r.key];
    endproperty
    a_disabled_skip: assert property (p_disabled_skip)
        else $error("Burst on disabled key.");

    property p_force;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        r.soft_rst |=> rst_req_r;
    endproperty
    a_force: assert property (p_force)
        else $error("Force reset not applied.");

    property p_miss_clear;
        @(posedge sys_clk_i) disable iff (!blk_rst_n)
        (r.st == S_WAIT && sample_vld_i && !sample_i.above) |=> r.bcnt == 4'h0;
    endproperty
    a_miss_clear: assert property (p_miss_clear)
        else $error("Integrator not cleared on miss.");

    property p_repeat;
        @(posedge sys_clk_i) disable iff (!blk_rst_n)
        (r.st == S_WAIT && sample_vld_i && sample_i.above && !r.cal &&
         r.bcnt + 4'h1 < setup_r[r.key].burst_lim) |=> ##1 burst_req_o;
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("Burst not repeated on same key.");

    property p_scan_clear;
        @(posedge sys_clk_i) disable iff (!blk_rst_n)
        (r.st == S_WAIT && sample_vld_i && !sample_i.above && !r.cal)
        |=> !r.active[$past(r.key)];
    endproperty
    a_scan_clear: assert property (p_scan_clear)
        else $error("Key stayed active after burst failure.");

    property p_cal_err;
        @(posedge sys_clk_i) disable iff (!blk_rst_n)
        (r.keyerr != $past(r.keyerr) && r.keyerr != '0) |-> !r.cal;
    endproperty
    a_cal_err: assert property (p_cal_err)
        else $error("Key error raised mid calibration.");

    property p_test_due;
        @(posedge sys_clk_i) disable iff (!blk_rst_n)
        r.test_due |-> r.st != S_INIT;
    endproperty
    a_test_due: assert property (p_test_due)
        else $error("Self-test due during init.");
endmodule
`default_nettype wire

// ---- touch_pkg.sv ----
// Purpose: Shared constants and types for the touch key sequencer.
// Assumes: One 10 MHz clock, AHB-Lite register access.
// Notes: Register addresses, reset values and self-test bit positions below.
package touch_pkg;
    localparam int NKEYS = 24;
    localparam int CLK_HZ = 10_000_000;
    localparam int INIT_US = 4000;
    localparam int INIT_MOD_US = 22000;
    localparam int RST_MIN_US = 10;
    localparam int INIT_CYC = INIT_US * (CLK_HZ / 1_000_000);
    localparam int INIT_MOD_CYC = INIT_MOD_US * (CLK_HZ / 1_000_000);
    localparam int RST_MIN_CYC = RST_MIN_US * (CLK_HZ / 1_000_000);
    localparam int CAL_RETRY = 5;
    localparam int CAL_BURSTS = 8;
    localparam logic [7:0] CMD_FORCE_RESET = 8'h04;
    // Register byte addresses.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_ENABLE = 8'h08;
    localparam logic [7:0] A_ACTIVE = 8'h0C;
    localparam logic [7:0] A_CALBUSY = 8'h10;
    localparam logic [7:0] A_KEYERR = 8'h14;
    localparam logic [7:0] A_STERR = 8'h18;
    localparam logic [7:0] A_SPACING = 8'h1C;
    localparam logic [7:0] A_LIMITS = 8'h20;
    localparam logic [7:0] A_CMD = 8'h24;
    localparam logic [7:0] A_TESTPER = 8'h28;
    localparam logic [23:0] ENABLE_RST = 24'hFFFFFF;
    localparam logic [15:0] SPACING_RST = 16'h1388;
    localparam logic [23:0] TESTPER_RST = 24'h0F4240;
    localparam logic [3:0] BLIM_RST = 4'h5;
    localparam logic [3:0] SLIM_RST = 4'h3;
    localparam logic [7:0] LSL_RST = 8'h10;
    // Self-test fault bit positions.
    localparam int ST_XSUP = 0;
    localparam int ST_XPIN = 1;
    localparam int ST_XDEV = 2;
    localparam int ST_YSUP = 3;
    localparam int ST_YPIN = 4;
    localparam int ST_XY = 5;
    localparam int ST_CS = 6;
    localparam int ST_VREF = 7;
    localparam int ST_GAIN = 8;
    localparam int ST_LSL = 9;
    localparam int ST_BITS = 10;

    typedef struct packed {
        logic       above;   // Burst result crossed threshold.
        logic [7:0] level;   // Signal level of the burst.
    } sample_t;

    typedef struct packed {
        logic [3:0] burst_lim;
        logic [3:0] scan_lim;
    } key_setup_t;
endpackage

// ---- rst_qual.sv ----
// Purpose: Synchronise and length-qualify the external reset pin.
// Assumes: Pin is active low.
// Notes: Emits a one-cycle pulse after a qualified low pulse ends.
`timescale 1ns/1ns
`default_nettype none
module rst_qual
    import touch_pkg::*;
#(
    parameter int MIN_CYC = RST_MIN_CYC
) (
    input wire logic sys_clk_i,   // System clock.
    input wire logic resetn_i,    // Power-on reset.
    input wire logic pin_n_i,     // External reset pin.
    output logic hit_o            // Qualified reset pulse.
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic [7:0] cnt;
        logic hit;
    } st_t;
    st_t r, nxt;

    // Count low time of the synchronised pin; fire on release if long enough.
    always_comb begin
        nxt = r;
        nxt.s1 = pin_n_i;
        nxt.s2 = r.s1;
        nxt.hit = 1'b0;
        if (!r.s2) begin
            if (r.cnt != 8'hFF) begin
                nxt.cnt = r.cnt + 8'h01;
            end
        end else begin
            nxt.hit = (r.cnt >= 8'(MIN_CYC));
            nxt.cnt = 8'h00;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '{s1: 1'b1, s2: 1'b1, cnt: 8'h00, hit: 1'b0};
        end else begin
            r <= nxt;
        end
    end
    assign hit_o = r.hit;

    property p_short_ignored;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (r.s2 && r.cnt < 8'(MIN_CYC)) |=> !r.hit;
    endproperty
    a_short_ignored: assert property (p_short_ignored)
        else $error("Short reset pulse was accepted.");
endmodule
`default_nettype wire

// ---- self_test.sv ----
// Purpose: Evaluate fault inputs for enabled keys in the dummy slot.
// Assumes: Fault inputs are valid when slot_i pulses.
// Notes: Flags refresh each slot; host filters transients.
`timescale 1ns/1ns
`default_nettype none
module self_test
    import touch_pkg::*;
(
    input wire logic sys_clk_i,                 // System clock.
    input wire logic rst_n_i,                   // Block reset.
    input wire logic slot_i,                    // Dummy slot pulse.
    input wire logic [NKEYS-1:0] enable_i,      // Enabled keys.
    input wire logic [NKEYS-1:0] key_fault_i,   // Per-key gain or Cs faults.
    input wire logic [NKEYS-1:0] low_sig_i,     // Below lower signal limit.
    input wire logic [ST_BITS-1:0] line_i,      // Raw line and ref faults.
    output logic [ST_BITS-1:0] err_o            // Latched self-test errors.
);
    typedef struct packed {
        logic [ST_BITS-1:0] err;
    } st_t;
    st_t r, nxt;

    // Per-key checks are masked by enable so disabled keys never fault.
    always_comb begin
        nxt = r;
        if (slot_i) begin
            nxt.err = line_i;
            nxt.err[ST_GAIN] = |(key_fault_i & enable_i);
            nxt.err[ST_LSL] = |(low_sig_i & enable_i);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end
    assign err_o = r.err;

    property p_lsl;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        slot_i |=> err_o[ST_LSL] == |($past(low_sig_i) & $past(enable_i));
    endproperty
    a_lsl: assert property (p_lsl)
        else $error("Lower signal limit flag wrong.");
endmodule
`default_nettype wire

// ---- front_end_model.sv ----
// Purpose: Burst front end that answers each burst request with a sample.
// Assumes: One sample per request; slow_i adds seven cycles of delay.
// Notes: Outside a valid cycle the sample bus toggles, never holds.
`timescale 1ns/1ns
`default_nettype none
module front_end_model
    import touch_pkg::*;
(
    input wire logic sys_clk_i,      // System clock.
    input wire logic resetn_i,       // Reset, low.
    input wire logic burst_req_i,    // Burst start pulse.
    input wire logic slow_i,         // Answer late.
    input wire logic above_i,        // Threshold crossed.
    input wire logic [7:0] level_i,  // Signal level.
    output logic sample_vld_o,       // Sample valid pulse.
    output sample_t sample_o         // Sample bus.
);
    logic pend_r;
    logic [3:0] wait_r;

    // --------------------------------------------------------------
    // Answer logic
    // --------------------------------------------------------------
    // Stale data is inverted so the design cannot lean on held values.
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_r <= 1'b0;
            wait_r <= 4'h0;
            sample_vld_o <= 1'b0;
            sample_o <= '0;
        end else begin
            sample_vld_o <= 1'b0;
            sample_o <= ~sample_o;
            if (burst_req_i) begin
                pend_r <= 1'b1;
                wait_r <= slow_i ? 4'h7 : 4'h0;
            end else if (pend_r && wait_r == 4'h0) begin
                pend_r <= 1'b0;
                sample_vld_o <= 1'b1;
                sample_o <= {above_i, level_i};
            end else if (pend_r) begin
                wait_r <= wait_r - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the touch key sequencer.
// Assumes: Short init counts of 50 and 200 cycles.
// Notes: Reads note their expected data in a queue for the monitor.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import touch_pkg::*;
    logic sys_clk_i = 0, resetn_i = 0, ext_rst_n_i = 1, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rng = 32'he94f6700;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic hreadyout, hresp, vld, req, rdy, slow = 0, above = 0, rd_dp = 0;
    logic [7:0] level = 8'h80;
    logic [4:0] key;
    logic [23:0] en_mask = 24'hFFFFFF;
    logic [NKEYS-1:0] kf = '0;
    logic [ST_BITS-1:0] flt = '0;
    sample_t smp;
    logic [31:0] exp_q[$];
    int err_total = 0, check_count = 0, cyc = 0;

    touch_seq #(.INIT_CYCLES(50), .INIT_MOD_CYCLES(200)) touch_seq_i (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ext_rst_n_i(ext_rst_n_i),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sample_vld_i(vld),
        .sample_i(smp), .key_fault_i(kf), .line_i(flt),
        .burst_req_o(req), .burst_key_o(key), .comms_ready_o(rdy));
    front_end_model front_end_model_i (.sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i), .burst_req_i(req), .slow_i(slow),
        .above_i(above), .level_i(level), .sample_vld_o(vld), .sample_o(smp));

    // ----------------------------------------------------------------
    // Clock, random levels and monitor
    // ----------------------------------------------------------------
    always #50 sys_clk_i = ~sys_clk_i;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Levels stay above the lower signal limit so no flag is provoked.
    always @(posedge sys_clk_i) begin
        rng = xs(rng);
        level <= rng[7:0] | 8'h80;
        slow <= rng[8];
        cyc++;
        if (rd_dp && hreadyout === 1'b1) check(hrdata, exp_q.pop_front());
        if (req === 1'b1) check({31'h0, en_mask[key]}, 32'h1);
        if (cyc == 60000) begin
            err_total++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------
    // Bus and sequencing tasks
    // ----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge sys_clk_i);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0;
        if (!wr) exp_q.push_back(d);
        rd_dp <= !wr;
        do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
        check({31'h0, hresp}, 32'h0);
    endtask
    task automatic wait_ready(input int lo, input int hi);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < hi + 5) begin
            @(posedge sys_clk_i);
            n++;
        end
        check({31'h0, n >= lo && n <= hi}, 32'h1);
    endtask
    task automatic pin_pulse(input int len);
        ext_rst_n_i <= 1'b0;
        repeat (len) @(posedge sys_clk_i);
        ext_rst_n_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        wait_ready(40, 60);
        xfer(0, A_ENABLE, 32'h00FFFFFF);
        xfer(0, 8'h3C, 32'h0);
        $display("test power-on done");
        en_mask <= 24'h000001;
        xfer(1, A_ENABLE, 32'h1);
        xfer(1, A_SPACING, 32'h8);
        xfer(1, A_CTRL, 32'h1);
        repeat (3000) @(posedge sys_clk_i);
        // Key 0 never crosses during calibration, so it ends in error.
        xfer(0, A_CALBUSY, 32'h0);
        xfer(0, A_KEYERR, 32'h1);
        xfer(0, A_STAT, 32'h200 | CAL_RETRY);
        above <= 1'b1;
        repeat (2000) @(posedge sys_clk_i);
        xfer(0, A_ACTIVE, 32'h1);
        above <= 1'b0;
        repeat (800) @(posedge sys_clk_i);
        xfer(0, A_ACTIVE, 32'h0);
        $display("test detect done");
        // A line fault must show; a gain fault on disabled key 5 must not.
        flt[ST_XSUP] <= 1'b1;
        kf[5] <= 1'b1;
        repeat (100) @(posedge sys_clk_i);
        xfer(0, A_STERR, 32'(1 << ST_XSUP));
        repeat (200) @(posedge sys_clk_i);
        xfer(0, A_STERR, 32'(1 << ST_XSUP));
        flt <= '0;
        kf <= '0;
        $display("test self-test done");
        en_mask <= 24'hFFFFFF;
        xfer(1, A_CMD, {24'h0, CMD_FORCE_RESET});
        repeat (4) @(posedge sys_clk_i);
        check({31'h0, rdy}, 32'h0);
        repeat (150) @(posedge sys_clk_i);
        check({31'h0, rdy}, 32'h0);
        wait_ready(30, 60);
        $display("test soft reset done");
        pin_pulse(20);
        check({31'h0, rdy}, 32'h1);
        pin_pulse(110);
        check({31'h0, rdy}, 32'h0);
        wait_ready(35, 55);
        xfer(0, A_ENABLE, 32'h00FFFFFF);
        $display("test pin reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
